/* File: common/wwdt_regs.vh */
// Constants of the windowed watchdog timer: offsets, fields, resets, counts.
// Overview of operation
// RQ1: Counter runs from RC oscillator; enable starts it.
// RQ2: Watchdog input clock nominally 32 kHz.
// RQ3: One bit selects divide-by-32 or divide-by-128.
// RQ4: Four-bit postscaler gives ratios 1:1 to 1:32768.
// RQ5: Any device reset clears counter and scalers.
// RQ6: Completed clock switch clears counter and scalers.
// RQ7: Entering sleep or idle clears counter, scalers.
// RQ8: Leaving sleep or idle clears them again.
// RQ9: Kick instruction in normal run clears counters.
// RQ10: Enabled watchdog keeps counting in sleep, idle.
// RQ11: Time-out in sleep or idle wakes device.
// RQ12: Software clears sleep and idle status itself.
// RQ13: Enable code 11 runs watchdog always.
// RQ14: Enable code 10 runs only with soft enable.
// RQ15: Every device reset clears the soft enable.
// RQ16: Time-out flag is sticky until software clears.
// RQ17: Window disable bit zero selects window mode.
// RQ18: Window codes 11,10,01,00 give 25,37.5,50,75 percent.
// RQ19: Run-mode time-out resets device, flag kept.
// RQ20: Early kick in window mode resets device.
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

// ****************************************************************
// Register byte addresses on the APB bus.
// ****************************************************************
`define WWDT_ADDR_CONFIG 12'h000
`define WWDT_ADDR_STATUS 12'h004
`define WWDT_ADDR_COUNT 12'h008

// ****************************************************************
// Field positions in the watchdog configuration word.
// ****************************************************************
`define WWDT_CFG_POST_MSB 3
`define WWDT_CFG_POST_LSB 0
`define WWDT_CFG_PRE 4
`define WWDT_CFG_EN_MSB 6
`define WWDT_CFG_EN_LSB 5
`define WWDT_CFG_WINDOW_DISABLE 7
`define WWDT_CFG_WIN_MSB 9
`define WWDT_CFG_WIN_LSB 8
`define WWDT_CFG_WIDTH 10
`define WWDT_CONFIG_RESET 10'h0DF

// ****************************************************************
// Field positions in the reset status register.
// ****************************************************************
`define WWDT_ST_IDLE 2
`define WWDT_ST_SLEEP 3
`define WWDT_ST_TIMEOUT 4
`define WWDT_ST_SWEN 5

// ****************************************************************
// Encodings and counts.
// ****************************************************************
`define WWDT_EN_ALWAYS 2'h3
`define WWDT_EN_SOFT 2'h2
`define WWDT_WIN_25 2'h3
`define WWDT_WIN_37 2'h2
`define WWDT_WIN_50 2'h1
`define WWDT_LOW_POWER_RC_OSCILLATOR_KHZ 32
`define WWDT_PRE_TOP_32 7'h1F
`define WWDT_PRE_TOP_128 7'h7F

`endif

/* File: dv/wwdt_assertions.sv */
// Port checker of the windowed watchdog timer, with its bind.
`timescale 1ns/1ns
`default_nettype none
module wwdt_assertions
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  // Core events and watchdog results.
  input wire logic power_save_instruction,
  input wire logic device_reset,
  input wire logic low_power_rc_oscillator_enable,
  input wire logic low_power_mode,
  input wire logic wake_request,
  input wire logic watchdog_reset_request
);
  // ********
  // Checks.
  // ********
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // A setup cycle is answered by a ready that stands for one cycle.
  sequence s_setup;
    psel && !penable && !pready && clk_en;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_bus_answer: assert property (s_setup |=> s_answer)
    else $error("bus answer late or too long");
  a_bus_unmapped: assert property (pready |->
    pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008))
    else $error("error response on wrong address");
  a_wake_from_sleep: assert property (
    wake_request |-> $past(low_power_mode))
    else $error("wake outside low power");
  a_reset_in_run: assert property (
    watchdog_reset_request |-> !$past(low_power_mode))
    else $error("device reset request in low power");
  a_reset_one_cycle: assert property (
    watchdog_reset_request |=> !watchdog_reset_request)
    else $error("reset request longer than one cycle");
  a_idle_quiet: assert property (
    !$past(low_power_rc_oscillator_enable) |-> !watchdog_reset_request && !wake_request)
    else $error("request while stopped");
  a_sleep_keeps_run: assert property (
    low_power_rc_oscillator_enable && low_power_mode && !psel && !device_reset
    |=> low_power_rc_oscillator_enable)
    else $error("watchdog stopped in low power");
  a_sleep_entry: assert property (
    power_save_instruction && !device_reset |=> low_power_mode)
    else $error("low power not entered");
endmodule

bind wwdt_top wwdt_assertions wwdt_assertions_i
(
  .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .power_save_instruction(power_save_instruction),
  .device_reset(device_reset), .low_power_rc_oscillator_enable(low_power_rc_oscillator_enable),
  .low_power_mode(low_power_mode), .wake_request(wake_request),
  .watchdog_reset_request(watchdog_reset_request)
);
`default_nettype wire

/* File: dv/wwdt_top_test.sv */
// Self-checking testbench of the windowed watchdog timer.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_regs.vh"
module wwdt_top_test;
  // ********
  // Stimulus, observation and bookkeeping.
  // ********
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic osc = 0, kick = 0, psave = 0, idle = 0, cswitch = 0, dreset = 0;
  logic resume = 0, ce = 1, slverr, wk;
  wire pready, pslverr, low_power_rc_oscillator_enable, wake, wreq, lpm;
  wire [31:0] prdata;
  int err_total = 0, total_checks = 0, n, nreq = 0;
  time t0, dt;

  wwdt_top wwdt_top_i
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .low_power_rc_oscillator(osc), .low_power_rc_oscillator_enable(low_power_rc_oscillator_enable),
    .kick_instruction(kick), .power_save_instruction(psave),
    .power_save_idle(idle), .clock_switch_done(cswitch),
    .device_reset(dreset), .resume_event(resume), .wake_request(wake),
    .watchdog_reset_request(wreq), .low_power_mode(lpm)
  );

  // System clock and a free oscillator of unrelated phase.
  always #5 sys_clk = ~sys_clk;
  always #103 osc = ~osc;

  // Counts device reset requests.
  always @(posedge sys_clk)
    if (wreq === 1'b1)
      nreq <= nreq + 1;

  task automatic check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // One bus transfer; holds the request until ready is sampled.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1);
    check(n < 50, "bus timeout");
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle core event: 0 kick, 1 resume, 2 power save, 3 reset, 4 switch.
  task automatic pulse(input int k);
    @(posedge sys_clk);
    {cswitch, dreset, psave, resume, kick} <= 5'h01 << k;
    @(posedge sys_clk);
    {cswitch, dreset, psave, resume, kick} <= 5'h00;
    t0 = $time;
  endtask

  // Waits a bounded time for a request pulse.
  task automatic await(input int lim);
    for (n = 0; n < lim && wreq !== 1'b1 && wake !== 1'b1; n++)
      @(posedge sys_clk);
    wk = wake;
    dt = $time - t0;
  endtask

  // True when the last delay matches a number of oscillator ticks.
  function automatic logic near(input int tk);
    return dt + 300 > tk * 206 && dt < tk * 206 + 500;
  endfunction

  task automatic t_reset;
    apb(0, `WWDT_ADDR_CONFIG, 32'h0);
    check(rdata === 32'h000000DF, "config reset");
    apb(0, `WWDT_ADDR_STATUS, 32'h0);
    check(rdata === 32'h0 && low_power_rc_oscillator_enable === 1'b0, "status reset");
    apb(0, `WWDT_ADDR_COUNT, 32'h0);
    check(rdata === 32'h0, "count reset");
    apb(1, 12'h00C, 32'hFFFFFFFF);
    check(slverr === 1'b1, "unmapped write");
    apb(0, 12'h00C, 32'h0);
    check(slverr === 1'b1 && rdata === 32'h0, "unmapped read");
  endtask

  task automatic t_periods;
    logic [4:0] sel [4] = '{5'h00, 5'h01, 5'h02, 5'h10};
    int tk [4] = '{32, 64, 128, 128};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, `WWDT_ADDR_CONFIG, {27'h7, sel[i]});
      apb(1, `WWDT_ADDR_STATUS, 32'h0);
      pulse(0);
      check(low_power_rc_oscillator_enable === 1'b1, "oscillator on");
      apb(0, `WWDT_ADDR_STATUS, 32'h0);
      check(rdata[4] === 1'b0, "flag cleared");
      apb(0, `WWDT_ADDR_COUNT, 32'h0);
      check({rdata[24], rdata[15:0]} === 17'h10000, "count runs");
      await(3000);
      check(wk === 1'b0 && near(tk[i]), "period");
      apb(0, `WWDT_ADDR_STATUS, 32'h0);
      check(rdata[4] === 1'b1, "flag set");
    end
  endtask

  task automatic t_kick;
    int n0;
    apb(1, `WWDT_ADDR_CONFIG, 32'h0E0);
    n0 = nreq;
    repeat (5)
    begin
      pulse(0);
      repeat (400) @(posedge sys_clk);
    end
    check(nreq == n0, "kick holds off");
    // Clock enable low freezes the count past the point of time-out.
    pulse(0);
    repeat (300) @(posedge sys_clk);
    ce <= 1'b0;
    repeat (700) @(posedge sys_clk);
    check(nreq == n0 && wreq === 1'b0, "frozen");
    ce <= 1'b1;
    await(1500);
    check(n < 1500 && wk === 1'b0, "resumes");
  endtask

  task automatic t_enable;
    logic [1:0] c;
    for (int j = 0; j < 5; j++)
    begin
      c = (j > 3) ? 2'h2 : j[1:0];
      apb(1, `WWDT_ADDR_CONFIG, {24'h0, 1'b1, c, 5'h00});
      apb(1, `WWDT_ADDR_STATUS, {26'h0, j < 4, 5'h00});
      pulse(4);
      await(1500);
      check((n < 1500) === (c[1] && j < 4), "enable code");
    end
    apb(1, `WWDT_ADDR_STATUS, 32'h20);
    pulse(3);
    apb(0, `WWDT_ADDR_STATUS, 32'h0);
    check(rdata[5] === 1'b0 && low_power_rc_oscillator_enable === 1'b0, "soft off");
  endtask

  task automatic t_sleep;
    time t1;
    apb(1, `WWDT_ADDR_CONFIG, 32'h0E0);
    for (int k = 0; k < 2; k++)
    begin
      apb(1, `WWDT_ADDR_STATUS, 32'h0);
      pulse(0);
      repeat (300) @(posedge sys_clk);
      idle <= k[0];
      pulse(2);
      t1 = t0;
      repeat (300) @(posedge sys_clk);
      pulse(0);
      t0 = t1;
      await(1500);
      check(wk === 1'b1 && near(32), "wake");
      apb(0, `WWDT_ADDR_STATUS, 32'h0);
      check(rdata[3:2] === {~k[0], k[0]} && lpm === 1'b0, "state");
    end
  endtask

  task automatic t_clear;
    for (int e = 2; e < 5; e++)
    begin
      pulse(0);
      repeat (400) @(posedge sys_clk);
      if (e == 2)
      begin
        pulse(2);
        repeat (100) @(posedge sys_clk);
        pulse(1);
      end
      else
        pulse(e);
      await(1500);
      check(wk === 1'b0 && near(32), "event clears");
    end
  endtask

  task automatic t_window;
    int st [4] = '{2, 4, 5, 6};
    int n0;
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `WWDT_ADDR_CONFIG, {22'h0, c[1:0], 8'h63});
      apb(1, `WWDT_ADDR_STATUS, 32'h0);
      n0 = nreq;
      pulse(4);
      repeat (st[c] * 659 - 329) @(posedge sys_clk);
      pulse(0);
      repeat (5) @(posedge sys_clk);
      check(nreq == n0 + 1, "early kick");
      pulse(4);
      repeat (st[c] * 659 + 330) @(posedge sys_clk);
      pulse(0);
      repeat (5) @(posedge sys_clk);
      check(nreq == n0 + 1, "kick in window");
    end
    apb(0, `WWDT_ADDR_STATUS, 32'h0);
    check(rdata[4] === 1'b1, "early kick flag");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_periods;
    t_kick;
    t_enable;
    t_sleep;
    t_clear;
    t_window;
    complete_run;
  end

  // Cuts a hang short.
  initial
  begin
    #1000000;
    err_total++;
    complete_run;
  end
endmodule
`default_nettype wire

/* File: hw/wwdt_top.v */
// Windowed watchdog timer with an APB register slave.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_regs.vh"

module wwdt_top
(
  // System clock, reset and clock enable.
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Low-power RC oscillator clock pin and its enable.
  input wire low_power_rc_oscillator,
  output reg low_power_rc_oscillator_enable,
  // Core events, one-cycle pulses on sys_clk.
  input wire kick_instruction,
  input wire power_save_instruction,
  input wire power_save_idle,
  input wire clock_switch_done,
  input wire device_reset,
  input wire resume_event,
  // Watchdog results.
  output reg wake_request,
  output reg watchdog_reset_request,
  output reg low_power_mode
);

  // ****************************************************************
  // Power states.
  // ****************************************************************
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_IDLE = 3'h4;

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // Postscale ratio: one shifted left by the four-bit code.
  function [15:0] post_ratio;
    input [3:0] code;
    begin
      post_ratio = 16'h0001 << code;
    end
  endfunction

  // First postscaler count at which the open window has begun.
  function [15:0] win_start;
    input [3:0] code;
    input [1:0] win;
    reg [15:0] r;
    begin
      r = 16'h0001 << code;
      case (win)
        `WWDT_WIN_25: win_start = r - (r >> 2);
        `WWDT_WIN_37: win_start = (r >> 1) + (r >> 3);
        `WWDT_WIN_50: win_start = r >> 1;
        default: win_start = r >> 2;
      endcase
      // Short periods: keep at least the final count open.
      if (win_start > r - 16'h0001)
        win_start = r - 16'h0001;
    end
  endfunction

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  reg [`WWDT_CFG_WIDTH-1:0] config_word;
  reg soft_watchdog_enable, timeout_flag, sleep_status, idle_status;
  reg [2:0] power_state, next_power_state;
  reg low_power_rc_oscillator_s1, low_power_rc_oscillator_s2, low_power_rc_oscillator_s3, low_power_rc_oscillator_level, low_power_rc_oscillator_level_d;
  reg [6:0] pre_cnt;
  reg [15:0] post_cnt;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire [3:0] postscale_select;
  wire [1:0] watchdog_enable_config, window_size_select;
  wire [6:0] pre_top;
  wire prescale_select, window_disable, run, low_power_rc_oscillator_tick, pre_done;
  wire timeout, in_run, kick_normal, window_open, window_fault;
  wire exit_low_power, wdt_reset, clear_all, apb_setup, apb_done;
  wire wr_config, wr_status;

  // ****************************************************************
  // Configuration fields.
  // ****************************************************************

  // Slices of the configuration word.
  assign postscale_select =
    config_word[`WWDT_CFG_POST_MSB:`WWDT_CFG_POST_LSB];
  assign prescale_select = config_word[`WWDT_CFG_PRE];
  assign watchdog_enable_config =
    config_word[`WWDT_CFG_EN_MSB:`WWDT_CFG_EN_LSB];
  assign window_disable = config_word[`WWDT_CFG_WINDOW_DISABLE];
  assign window_size_select =
    config_word[`WWDT_CFG_WIN_MSB:`WWDT_CFG_WIN_LSB];

  // Run when forced on, or when soft mode and software enable is set.
  assign run = (watchdog_enable_config == `WWDT_EN_ALWAYS) | // see RQ13
    ((watchdog_enable_config == `WWDT_EN_SOFT) &
    soft_watchdog_enable); // see RQ14

  // ****************************************************************
  // Oscillator clock sampling.
  // ****************************************************************

  // Three-flop chain; the filtered level moves only when the second
  // and third stage agree, so a slow edge counts once.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_power_rc_oscillator_s1 <= 1'b0;
      low_power_rc_oscillator_s2 <= 1'b0;
      low_power_rc_oscillator_s3 <= 1'b0;
      low_power_rc_oscillator_level <= 1'b0;
      low_power_rc_oscillator_level_d <= 1'b0;
    end
    else if (clk_en)
    begin
      low_power_rc_oscillator_s1 <= low_power_rc_oscillator;
      low_power_rc_oscillator_s2 <= low_power_rc_oscillator_s1;
      low_power_rc_oscillator_s3 <= low_power_rc_oscillator_s2;
      if (low_power_rc_oscillator_s2 == low_power_rc_oscillator_s3)
        low_power_rc_oscillator_level <= low_power_rc_oscillator_s3;
      low_power_rc_oscillator_level_d <= low_power_rc_oscillator_level;
    end
  end

  // One tick per rising edge of the nominal 32 kHz clock.
  assign low_power_rc_oscillator_tick = low_power_rc_oscillator_level & ~low_power_rc_oscillator_level_d; // see RQ1, RQ2

  // ****************************************************************
  // Events.
  // ****************************************************************

  // Prescaler wraps after 32 or 128 oscillator ticks.
  assign pre_top = prescale_select ? `WWDT_PRE_TOP_128 :
    `WWDT_PRE_TOP_32; // see RQ3
  assign pre_done = low_power_rc_oscillator_tick & (pre_cnt == pre_top);

  // Time-out when the postscaler completes its selected ratio.
  assign timeout = run & pre_done &
    (post_cnt == post_ratio(postscale_select) - 16'h0001); // see RQ4

  assign in_run = (power_state == ST_RUN);
  assign kick_normal = kick_instruction & in_run & run;

  // Window is open once the closed share of the period has passed.
  assign window_open =
    (post_cnt >= win_start(postscale_select,
    window_size_select)); // see RQ18
  assign window_fault = kick_normal & ~window_disable &
    ~window_open; // see RQ17, RQ20

  // Leaving low power, by another cause or by a time-out.
  assign exit_low_power = ~in_run & (resume_event | timeout);

  // A run-mode time-out or early kick resets the device.
  assign wdt_reset = in_run & (timeout | window_fault); // see RQ19

  // Every cause that restarts the counter and both scalers.
  assign clear_all = device_reset | // see RQ5
    clock_switch_done | // see RQ6
    (power_save_instruction & in_run) | // see RQ7
    exit_low_power | // see RQ8
    kick_normal | // see RQ9
    timeout | wdt_reset;

  // ****************************************************************
  // Counters.
  // ****************************************************************

  // Prescaler and postscaler; they count in every power state.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_cnt <= 7'h00;
      post_cnt <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (clear_all | ~run)
      begin
        pre_cnt <= 7'h00;
        post_cnt <= 16'h0000;
      end
      else if (pre_done)
      begin
        pre_cnt <= 7'h00;
        post_cnt <= post_cnt + 16'h0001;
      end
      else if (low_power_rc_oscillator_tick)
        pre_cnt <= pre_cnt + 7'h01; // see RQ10
    end
  end

  // ****************************************************************
  // Power state machine.
  // ****************************************************************

  // Sleep or idle is entered by the instruction, left on resume or
  // on a watchdog time-out.
  always @*
  begin
    next_power_state = power_state;
    case (power_state)
      ST_RUN:
        if (power_save_instruction)
          next_power_state = power_save_idle ? ST_IDLE : ST_SLEEP;
      ST_SLEEP, ST_IDLE:
        if (exit_low_power)
          next_power_state = ST_RUN; // see RQ11
      default:
        next_power_state = ST_RUN;
    endcase
  end

  // State register and result pulses.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_state <= ST_RUN;
      wake_request <= 1'b0;
      watchdog_reset_request <= 1'b0;
      low_power_mode <= 1'b0;
      low_power_rc_oscillator_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      if (device_reset)
        power_state <= ST_RUN;
      else
        power_state <= next_power_state;
      wake_request <= ~in_run & timeout; // see RQ11
      watchdog_reset_request <= wdt_reset; // see RQ19
      low_power_mode <= ~device_reset & (next_power_state != ST_RUN);
      low_power_rc_oscillator_enable <= run; // see RQ1
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************

  // Setup cycle raises pready; the access cycle then completes.
  assign apb_setup = psel & ~penable & ~pready;
  assign apb_done = psel & penable & pready;
  assign wr_config = apb_done & pwrite & ~pslverr &
    (paddr == `WWDT_ADDR_CONFIG);
  assign wr_status = apb_done & pwrite & ~pslverr &
    (paddr == `WWDT_ADDR_STATUS);

  // Read data and error answer, chosen from the address.
  always @*
  begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `WWDT_ADDR_CONFIG:
        next_prdata[`WWDT_CFG_WIDTH-1:0] = config_word;
      `WWDT_ADDR_STATUS:
      begin
        next_prdata[`WWDT_ST_IDLE] = idle_status;
        next_prdata[`WWDT_ST_SLEEP] = sleep_status;
        next_prdata[`WWDT_ST_TIMEOUT] = timeout_flag;
        next_prdata[`WWDT_ST_SWEN] = soft_watchdog_enable;
      end
      `WWDT_ADDR_COUNT:
      begin
        next_prdata[15:0] = post_cnt;
        next_prdata[22:16] = pre_cnt;
        next_prdata[24] = run;
      end
      default:
        next_pslverr = 1'b1;
    endcase
  end

  // Answer registers: data captured in the setup cycle.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (apb_setup)
      begin
        pready <= 1'b1;
        pslverr <= next_pslverr;
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration and status registers.
  // ****************************************************************

  // Configuration word, written by software.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      config_word <= `WWDT_CONFIG_RESET;
    else if (clk_en & wr_config)
      config_word <= pwdata[`WWDT_CFG_WIDTH-1:0];
  end

  // Status bits; a hardware set wins over a software clear in the
  // same cycle. Writing one to a sticky bit leaves it unchanged.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      soft_watchdog_enable <= 1'b0;
      timeout_flag <= 1'b0;
      sleep_status <= 1'b0;
      idle_status <= 1'b0;
    end
    else if (clk_en)
    begin
      if (device_reset | wdt_reset)
        soft_watchdog_enable <= 1'b0; // see RQ15
      else if (wr_status)
        soft_watchdog_enable <= pwdata[`WWDT_ST_SWEN]; // see RQ14
      // Flag survives device resets, including its own.
      timeout_flag <= timeout | window_fault |
        (timeout_flag &
        (~wr_status | pwdata[`WWDT_ST_TIMEOUT])); // see RQ16
      // Hardware only sets these; software clears them.
      sleep_status <= (power_save_instruction & in_run &
        ~power_save_idle) |
        (sleep_status &
        (~wr_status | pwdata[`WWDT_ST_SLEEP])); // see RQ12
      idle_status <= (power_save_instruction & in_run &
        power_save_idle) |
        (idle_status &
        (~wr_status | pwdata[`WWDT_ST_IDLE])); // see RQ12
    end
  end

endmodule
`default_nettype wire
